// [logic/rpd_pkg.sv]
package rpd_pkg;

    // Instruction codes that enter the two low-power states.
    localparam logic [7:0]  OPC_STOP       = 8'h7f;
    localparam logic [7:0]  OPC_IDLE       = 8'h6f;

    // Start address slots fetched after a reset stabilisation interval.
    localparam logic [15:0] RESET_VECTOR   = 16'h0100;
    localparam logic [15:0] RESET_VECTOR_2 = 16'h0101;

    // Basic timer control layout and reset value.
    localparam logic [7:0]  TMR_CTRL_RST   = 8'h00;
    localparam logic [3:0]  WDT_OFF_KEY    = 4'ha;
    localparam int          BT_KEY_LSB     = 4;
    localparam int          BT_STAB_LSB    = 2;
    localparam int          BT_CLEAR_BIT   = 1;

    // Clock divider control layout and reset value; wake bit low means wake enabled.
    localparam logic [7:0]  DIV_CTRL_RST   = 8'h00;
    localparam logic [7:0]  DIV_CTRL_MASK  = 8'h98;
    localparam int          CK_WAKE_BIT    = 7;
    localparam int          CK_DIV_LSB     = 3;

    // Divider selections and the last count of each division.
    localparam logic [1:0]  DIV_BY16       = 2'b00;
    localparam logic [1:0]  DIV_BY8        = 2'b01;
    localparam logic [1:0]  DIV_BY2        = 2'b10;
    localparam logic [3:0]  DIV16_LAST     = 4'hf;
    localparam logic [3:0]  DIV8_LAST      = 4'h7;
    localparam logic [3:0]  DIV2_LAST      = 4'h1;
    localparam logic [3:0]  DIV1_LAST      = 4'h0;

    // Clock rate and the oscillator settling interval in oscillator cycles.
    localparam int          CLK_HZ         = 25_000_000;
    localparam int          CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
    localparam int          OSC_STAB_CYC   = 65536;
    localparam int          WDT_CYC        = 262144;
    localparam int          CNT_W          = 20;

    // Sequencer states, one-hot.
    typedef enum logic [5:0]
    {
        ST_RESET = 6'b000001,
        ST_STAB  = 6'b000010,
        ST_RUN   = 6'b000100,
        ST_STOP  = 6'b001000,
        ST_IDLE  = 6'b010000,
        ST_WAKE  = 6'b100000
    } rpd_state_type;

endpackage : rpd_pkg

// [logic/rpd_sync.sv]
`timescale 1ns/1ps
module rpd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // Two flip-flops per bit; the first stage feeds only the second.
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                meta_q[i]   <= 1'b0;
                sync_out[i] <= 1'b0;
            end
            else if (clk_en)
            begin
                meta_q[i]   <= async_in[i];
                sync_out[i] <= meta_q[i];
            end
        end
    end

endmodule : rpd_sync

// [logic/rpd_top.sv]
// Contract
// [RQ1] Config bit picks internal droop reset or external pin; internal frees pin as port.
// [RQ2] Reset enters from power-on, reset pin low, watchdog timeout or supply droop.
// [RQ3] External reset input is synchronised to the clock before use.
// [RQ4] External driver holds reset pin low for the oscillator settling time.
// [RQ5] Reset pin low during run starts reset, loading control registers to defaults.
// [RQ6] Watchdog counter overflow without refresh asserts an internal reset.
// [RQ7] Droop below threshold holds static reset until supply rises again.
// [RQ8] Writing 1010B to basic timer control upper nibble disables the watchdog.
// [RQ9] Software sets stabilisation length before Stop; device applies it on exit.
// [RQ10] Reset disables interrupts, enables watchdog, makes ports input, inits peripherals.
// [RQ11] Reset loads start vector 0100H; after stabilisation the CPU fetches and runs.
// [RQ12] Opcode 7FH enters Stop: oscillator halts, everything stops, registers kept.
// [RQ13] Reset out of Stop resets controls, keeps data, selects divide by 16.
// [RQ14] Only filtered external or externally clocked interrupts end Stop.
// [RQ15] Interrupt out of Stop leaves all control registers and divider unchanged.
// [RQ16] After Stop wake the interrupt is served, then execution follows Stop.
// [RQ17] Opcode 6FH enters Idle: only CPU clock gated, timers and ports keep going.
// [RQ18] Reset ends Idle like Stop; with interrupts masked reset is the only exit.
// [RQ19] Any enabled interrupt ends Idle keeping divider, serves it, resumes after.
// [RQ20] Software disables the converter before Stop or Idle to limit current.
// [RQ21] Clock control bit 7 gates external interrupt wake from Stop; reset enables it.
// [RQ22] Divider select chooses oscillator undivided, or divided by 2, 8 or 16.
// [RQ23] After interrupt wake from Stop, CPU clock stays off until stabilisation ends.
`timescale 1ns/1ps
module rpd_top #(
    parameter int STAB_CYCLES = rpd_pkg::OSC_STAB_CYC,
    parameter int WDT_CYCLES  = rpd_pkg::WDT_CYC
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    input  wire logic       por_n,
    input  wire logic       reset_pin_n,
    input  wire logic       supply_droop_reset,
    input  wire logic       opt_internal_reset,
    input  wire logic [1:0] filtered_external_irq,
    input  wire logic       ext_clocked_irq,
    input  wire logic       irq_enabled_any,
    input  wire logic       cpu_exec,
    input  wire logic [7:0] cpu_opcode,
    input  wire logic       basic_timer_control_wr,
    input  wire logic [7:0] basic_timer_control_wdata,
    input  wire logic       clock_divider_control_wr,
    input  wire logic [7:0] clock_divider_control_wdata,
    output logic [7:0]      basic_timer_control_q,
    output logic [7:0]      clock_divider_control_q,
    output logic            ctrl_reset_q,
    output logic            data_reset_q,
    output logic            fetch_start_q,
    output logic            irq_service_q,
    output logic            osc_run_q,
    output logic            cpu_clk_en_q,
    output logic            in_stop_q,
    output logic            in_idle_q,
    output logic            watchdog_en_q,
    output logic            reset_pin_is_port_q,
    output logic            wdt_ovf_q
);

    localparam logic [rpd_pkg::CNT_W-1:0] STAB_LEN = rpd_pkg::CNT_W'(STAB_CYCLES);
    localparam logic [rpd_pkg::CNT_W-1:0] WDT_LAST = rpd_pkg::CNT_W'(WDT_CYCLES - 1);

    rpd_pkg::rpd_state_type     state_q;
    rpd_pkg::rpd_state_type     state_d;
    logic [5:0]                 pin_s;
    logic                       por_s;
    logic                       rpin_s;
    logic                       droop_s;
    logic [1:0]                 xirq_s;
    logic                       xclk_irq_s;
    logic                       opt_q;
    logic                       rst_src;
    logic                       stop_wake;
    logic                       keep_d;
    logic                       keep_q;
    logic [rpd_pkg::CNT_W-1:0]  stab_cnt_q;
    logic [rpd_pkg::CNT_W-1:0]  stab_last;
    logic                       stab_done;
    logic [rpd_pkg::CNT_W-1:0]  wdt_cnt_q;
    logic                       wdt_on;
    logic [3:0]                 div_cnt_q;
    logic [3:0]                 div_last;
    logic                       div_tick;
    logic                       is_stop_op;
    logic                       is_idle_op;

    // Pins and signals from other clocks pass two flip-flops first.
    rpd_sync #(
        .W (6)
    ) u_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .clk_en   (clk_en),
        .async_in ({ext_clocked_irq, filtered_external_irq, supply_droop_reset, reset_pin_n, por_n}),
        .sync_out (pin_s)
    ); // RQ3

    assign por_s      = pin_s[0];
    assign rpin_s     = pin_s[1];
    assign droop_s    = pin_s[2];
    assign xirq_s     = pin_s[4:3];
    assign xclk_irq_s = pin_s[5];

    // The pin counts only when the external source is selected; droop only when internal.
    assign rst_src = !por_s || (!opt_q && !rpin_s) || (opt_q && droop_s) || wdt_ovf_q; // RQ1 RQ2 RQ5 RQ6 RQ7

    // An interrupt ends Stop only on filtered pins gated by the wake bit, or externally clocked sources.
    assign stop_wake = (|xirq_s && !clock_divider_control_q[rpd_pkg::CK_WAKE_BIT])
                     || xclk_irq_s; // RQ14 RQ21

    assign is_stop_op = cpu_exec && cpu_clk_en_q && (cpu_opcode == rpd_pkg::OPC_STOP);
    assign is_idle_op = cpu_exec && cpu_clk_en_q && (cpu_opcode == rpd_pkg::OPC_IDLE);

    // Stabilisation length is the programmed fraction of the settling interval.
    assign stab_last = (STAB_LEN >> {basic_timer_control_q[rpd_pkg::BT_STAB_LSB +: 2], 1'b0})
                     - rpd_pkg::CNT_W'(1); // RQ9 RQ11
    assign stab_done = (stab_cnt_q == stab_last);

    assign wdt_on = (basic_timer_control_q[rpd_pkg::BT_KEY_LSB +: 4] != rpd_pkg::WDT_OFF_KEY); // RQ8

    // Next state; any reset source wins over every other event.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            rpd_pkg::ST_RESET: if (!rst_src) state_d = rpd_pkg::ST_STAB;
            rpd_pkg::ST_STAB:  if (stab_done) state_d = rpd_pkg::ST_RUN; // RQ11
            rpd_pkg::ST_RUN:
            begin
                if (is_stop_op)
                    state_d = rpd_pkg::ST_STOP; // RQ12
                else if (is_idle_op)
                    state_d = rpd_pkg::ST_IDLE; // RQ17
            end
            rpd_pkg::ST_STOP:  if (stop_wake) state_d = rpd_pkg::ST_WAKE; // RQ14
            rpd_pkg::ST_IDLE:  if (irq_enabled_any) state_d = rpd_pkg::ST_RUN; // RQ18 RQ19
            rpd_pkg::ST_WAKE:  if (stab_done) state_d = rpd_pkg::ST_RUN; // RQ23
            default:           state_d = rpd_pkg::ST_RESET;
        endcase
        if (rst_src)
            state_d = rpd_pkg::ST_RESET; // RQ2 RQ13 RQ18
    end

    // Data survives a reset that ends Stop or Idle, but not a power-on.
    always_comb
    begin
        keep_d = 1'b0;
        if (state_q == rpd_pkg::ST_STOP || state_q == rpd_pkg::ST_IDLE)
            keep_d = por_s; // RQ13 RQ18
        else if (state_q == rpd_pkg::ST_RESET)
            keep_d = keep_q && por_s;
    end

    // Sequencer state register.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= rpd_pkg::ST_RESET;
        else if (clk_en)
            state_q <= state_d;
    end

    // Status outputs registered from the next state.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            keep_q        <= 1'b0;
            ctrl_reset_q  <= 1'b1;
            data_reset_q  <= 1'b1;
            fetch_start_q <= 1'b0;
            irq_service_q <= 1'b0;
            osc_run_q     <= 1'b1;
            in_stop_q     <= 1'b0;
            in_idle_q     <= 1'b0;
        end
        else if (clk_en)
        begin
            keep_q        <= keep_d;
            ctrl_reset_q  <= (state_d == rpd_pkg::ST_RESET); // RQ5 RQ10
            data_reset_q  <= (state_d == rpd_pkg::ST_RESET) && !keep_d; // RQ10 RQ13
            fetch_start_q <= (state_q == rpd_pkg::ST_STAB) && (state_d == rpd_pkg::ST_RUN); // RQ11
            irq_service_q <= (state_q == rpd_pkg::ST_WAKE || state_q == rpd_pkg::ST_IDLE)
                          && (state_d == rpd_pkg::ST_RUN); // RQ16 RQ19
            osc_run_q     <= (state_d != rpd_pkg::ST_STOP); // RQ12
            in_stop_q     <= (state_d == rpd_pkg::ST_STOP);
            in_idle_q     <= (state_d == rpd_pkg::ST_IDLE); // RQ17
        end
    end

    // Configuration bit is caught while reset is held, so it is steady afterwards.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            opt_q <= 1'b0;
        else if (clk_en && state_q == rpd_pkg::ST_RESET)
            opt_q <= opt_internal_reset; // RQ1
    end

    assign reset_pin_is_port_q = opt_q; // RQ1

    // Control registers: defaults during reset, software writes only while running.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            basic_timer_control_q   <= rpd_pkg::TMR_CTRL_RST;
            clock_divider_control_q <= rpd_pkg::DIV_CTRL_RST;
        end
        else if (clk_en)
        begin
            if (state_q == rpd_pkg::ST_RESET)
            begin
                basic_timer_control_q   <= rpd_pkg::TMR_CTRL_RST; // RQ5 RQ10
                clock_divider_control_q <= rpd_pkg::DIV_CTRL_RST; // RQ13 RQ18 RQ21
            end
            else if (state_q == rpd_pkg::ST_RUN) // RQ15
            begin
                if (basic_timer_control_wr)
                    basic_timer_control_q <= basic_timer_control_wdata; // RQ8 RQ9
                if (clock_divider_control_wr)
                    clock_divider_control_q <= clock_divider_control_wdata & rpd_pkg::DIV_CTRL_MASK;
            end
        end
    end

    // Watchdog enable follows the key nibble; it is on after every reset.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            watchdog_en_q <= 1'b1;
        else if (clk_en)
            watchdog_en_q <= (state_q == rpd_pkg::ST_RESET) || wdt_on; // RQ10
    end

    // Stabilisation counter runs after reset and after an interrupt wake from Stop.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            stab_cnt_q <= '0;
        else if (clk_en)
        begin
            if ((state_q == rpd_pkg::ST_STAB || state_q == rpd_pkg::ST_WAKE) && !stab_done)
                stab_cnt_q <= stab_cnt_q + rpd_pkg::CNT_W'(1); // RQ9 RQ23
            else
                stab_cnt_q <= '0;
        end
    end

    // Watchdog counts in Run and Idle; a refresh write restarts it.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wdt_cnt_q <= '0;
            wdt_ovf_q <= 1'b0;
        end
        else if (clk_en)
        begin
            wdt_ovf_q <= 1'b0;
            if (state_q != rpd_pkg::ST_RUN && state_q != rpd_pkg::ST_IDLE)
                wdt_cnt_q <= '0;
            else if (state_q == rpd_pkg::ST_RUN && basic_timer_control_wr
                     && basic_timer_control_wdata[rpd_pkg::BT_CLEAR_BIT])
                wdt_cnt_q <= '0;
            else if (wdt_cnt_q == WDT_LAST)
            begin
                wdt_cnt_q <= '0;
                wdt_ovf_q <= wdt_on; // RQ6 RQ8
            end
            else
                wdt_cnt_q <= wdt_cnt_q + rpd_pkg::CNT_W'(1);
        end
    end

    // Last divider count for the selected CPU clock rate.
    always_comb
    begin
        case (clock_divider_control_q[rpd_pkg::CK_DIV_LSB +: 2])
            rpd_pkg::DIV_BY16: div_last = rpd_pkg::DIV16_LAST;
            rpd_pkg::DIV_BY8:  div_last = rpd_pkg::DIV8_LAST;
            rpd_pkg::DIV_BY2:  div_last = rpd_pkg::DIV2_LAST;
            default:           div_last = rpd_pkg::DIV1_LAST;
        endcase
    end

    assign div_tick = (div_cnt_q >= div_last); // RQ22

    // CPU clock enable pulses only in Run; Idle and Stop gate it off.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_cnt_q    <= '0;
            cpu_clk_en_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (state_q != rpd_pkg::ST_RUN || div_tick)
                div_cnt_q <= '0;
            else
                div_cnt_q <= div_cnt_q + 4'h1;
            cpu_clk_en_q <= (state_q == rpd_pkg::ST_RUN) && (state_d == rpd_pkg::ST_RUN)
                         && div_tick; // RQ17 RQ22 RQ23
        end
    end

    // Droop with the internal source chosen holds reset.
    a_droop_holds_reset: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && opt_q && droop_s |=> state_q == rpd_pkg::ST_RESET) // RQ7
        else $error("droop did not hold reset");

    // Pin ignored when the internal source is chosen.
    a_pin_port_mode: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && opt_q && por_s && !droop_s && !wdt_ovf_q && !rpin_s && state_q == rpd_pkg::ST_RUN
        |=> state_q != rpd_pkg::ST_RESET) // RQ1
        else $error("reset pin acted in port mode");

    // Stop opcode halts the oscillator next cycle.
    a_stop_entry: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && state_q == rpd_pkg::ST_RUN && is_stop_op && !rst_src
        |=> in_stop_q && !osc_run_q && !cpu_clk_en_q) // RQ12
        else $error("stop entry wrong");

    // Key nibble suppresses watchdog overflow.
    a_wdt_key_off: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && basic_timer_control_q[rpd_pkg::BT_KEY_LSB +: 4] == rpd_pkg::WDT_OFF_KEY |=> !wdt_ovf_q) // RQ8
        else $error("watchdog fired while disabled");

    // Watchdog overflow forces reset.
    a_wdt_resets: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && wdt_ovf_q |=> state_q == rpd_pkg::ST_RESET && ctrl_reset_q) // RQ6
        else $error("watchdog overflow without reset");

    // Reset returns the divider to divide by 16 and enables wake.
    a_reset_div16: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && state_q == rpd_pkg::ST_RESET |=> clock_divider_control_q == rpd_pkg::DIV_CTRL_RST) // RQ13
        else $error("reset left divider set");

    // Interrupt wake from Stop keeps the clock divider control register.
    a_stop_keeps_ctrl: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == rpd_pkg::ST_STOP && !rst_src |=> $stable(clock_divider_control_q)) // RQ15
        else $error("stop wake changed controls");

    // Without a qualified source Stop persists.
    a_stop_no_wake: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && state_q == rpd_pkg::ST_STOP && !rst_src && !stop_wake |=> state_q == rpd_pkg::ST_STOP) // RQ14
        else $error("stop ended without qualified source");

    // Enabled interrupt ends Idle and is served next cycle.
    a_idle_wake: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && state_q == rpd_pkg::ST_IDLE && irq_enabled_any && !rst_src
        |=> state_q == rpd_pkg::ST_RUN && irq_service_q) // RQ19
        else $error("idle wake not taken");

    // CPU clock stays off during post-wake stabilisation.
    a_wake_cpu_off: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == rpd_pkg::ST_WAKE |-> !cpu_clk_en_q && !irq_service_q) // RQ23
        else $error("cpu clock ran during stabilisation");

endmodule : rpd_top

// [tb/rpd_reset_source.sv]
`timescale 1ns/1ps
// Far-side reset circuit: holds power-on and reset pin low for a settling span.
module rpd_reset_source #(
    parameter int HOLD = 8
) (
    input  wire logic clk,
    input  wire logic pin_req,
    output logic      por_n,
    output logic      reset_pin_n
);
    logic [7:0] por_cnt = 8'h00;
    logic [7:0] pin_cnt = 8'h00;

    // Power-on stays low for HOLD cycles; a pin request pulls the pin low as long.
    always @(posedge clk)
    begin
        if (por_cnt < 8'(HOLD))
            por_cnt <= por_cnt + 8'h01;
        if (pin_req)
            pin_cnt <= 8'(HOLD);
        else if (pin_cnt != 8'h00)
            pin_cnt <= pin_cnt - 8'h01;
    end

    // The pin has a pull-up, so a released pin reads high.
    assign por_n       = (por_cnt >= 8'(HOLD));
    assign reset_pin_n = (pin_cnt == 8'h00);
endmodule : rpd_reset_source

// [tb/rpd_top_bench.sv]
`timescale 1ns/1ps
module rpd_top_bench;
    localparam int STAB = 256;
    localparam int WDT  = 512;
    localparam int DIVS [4] = '{16, 8, 2, 1};
    logic       clk = 1'h0;
    logic       arst_n = 1'h0;
    logic       pin_req = 1'h0;
    logic       por_n;
    logic       reset_pin_n;
    logic       supply_droop_reset = 1'h0;
    logic       opt_internal_reset = 1'h0;
    logic [1:0] filtered_external_irq = 2'h0;
    logic       ext_clocked_irq = 1'h0;
    logic       irq_enabled_any = 1'h0;
    logic       cpu_exec = 1'h0;
    logic [7:0] cpu_opcode = 8'h00;
    logic       basic_timer_control_wr = 1'h0;
    logic [7:0] basic_timer_control_wdata = 8'h00;
    logic       clock_divider_control_wr = 1'h0;
    logic [7:0] clock_divider_control_wdata = 8'h00;
    logic [7:0] basic_timer_control_q;
    logic [7:0] clock_divider_control_q;
    logic       ctrl_reset_q, data_reset_q, fetch_start_q, irq_service_q, osc_run_q;
    logic       cpu_clk_en_q, in_stop_q, in_idle_q, watchdog_en_q, reset_pin_is_port_q, wdt_ovf_q;
    logic       clk_seen;
    int         n;
    int         n_mismatch = 0;
    int         check_count = 0;

    rpd_reset_source #(.HOLD(8)) partner (.clk, .pin_req, .por_n, .reset_pin_n);

    rpd_top #(.STAB_CYCLES(STAB), .WDT_CYCLES(WDT)) dut (
        .clk, .arst_n, .clk_en(1'h1), .por_n, .reset_pin_n, .supply_droop_reset, .opt_internal_reset,
        .filtered_external_irq, .ext_clocked_irq, .irq_enabled_any, .cpu_exec, .cpu_opcode,
        .basic_timer_control_wr, .basic_timer_control_wdata, .clock_divider_control_wr,
        .clock_divider_control_wdata, .basic_timer_control_q, .clock_divider_control_q, .ctrl_reset_q,
        .data_reset_q, .fetch_start_q, .irq_service_q, .osc_run_q, .cpu_clk_en_q, .in_stop_q, .in_idle_q,
        .watchdog_en_q, .reset_pin_is_port_q, .wdt_ovf_q);

    // The clock toggles every 20 ns, half of its 40 ns period.
    always #20 clk = ~clk;

    // Compares one value and reports a mismatch at once.
    task check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check

    // Moves to just after the next rising edge.
    task step();
        @(posedge clk);
        #1;
    endtask : step

    // Waits a bounded number of cycles for one output, counting cycles in n.
    task wait_for(input int which, input int lim);
        logic hit;
        n = 0;
        hit = 1'h0;
        clk_seen = 1'h0;
        while (hit !== 1'h1 && n < lim)
        begin
            step();
            n++;
            clk_seen = clk_seen | cpu_clk_en_q;
            case (which)
                0: hit = fetch_start_q;
                1: hit = irq_service_q;
                2: hit = wdt_ovf_q;
                3: hit = cpu_clk_en_q;
                default: hit = ctrl_reset_q;
            endcase
        end
        check(8'(hit), 8'h01, "awaited event missing");
    endtask : wait_for

    // Writes one control register with a single-cycle strobe.
    task wr(input logic bt, input logic [7:0] d);
        step();
        basic_timer_control_wr = bt;
        clock_divider_control_wr = !bt;
        basic_timer_control_wdata = d;
        clock_divider_control_wdata = d;
        step();
        basic_timer_control_wr = 1'h0;
        clock_divider_control_wr = 1'h0;
    endtask : wr

    // Holds an opcode until the sequencer takes it on a CPU clock cycle.
    task exec(input logic [7:0] op);
        cpu_opcode = op;
        cpu_exec = 1'h1;
        n = 0;
        while ((in_stop_q | in_idle_q) !== 1'h1 && n < 40)
        begin
            step();
            n++;
        end
        cpu_exec = 1'h0;
    endtask : exec

    // Prints the counts and the verdict, then ends the run.
    task end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    // Cuts a hang short well beyond the expected run length.
    initial
    begin
        #400000;
        n_mismatch++;
        end_of_test();
    end

    // Main sequence of scenarios.
    initial
    begin
        repeat (5) @(posedge clk);
        #1;
        check(8'(ctrl_reset_q), 8'h01, "reset level");
        check(8'(watchdog_en_q), 8'h01, "watchdog armed");
        check(basic_timer_control_q, 8'h00, "timer control default");
        check(clock_divider_control_q, 8'h00, "divider default");
        arst_n = 1'h1;
        wait_for(0, STAB + 40);
        check(8'(n >= STAB), 8'h01, "start before settling");
        repeat (WDT - 100) step();
        wr(1'h1, 8'h02);
        wait_for(2, WDT + 20);
        check(8'(n == WDT), 8'h01, "refresh ignored");
        step();
        check(8'(ctrl_reset_q), 8'h01, "overflow reset");
        wait_for(0, STAB + 8);
        wr(1'h1, 8'ha4);
        step();
        check(8'(watchdog_en_q), 8'h00, "watchdog off");
        for (int i = 0; i < 4; i++)
        begin
            wr(1'h0, 8'h67 | 8'(i << 3));
            check(clock_divider_control_q, 8'(i << 3), "masked divider");
            wait_for(3, 20);
            wait_for(3, 20);
            check(8'(n), 8'(DIVS[i]), "divider spacing");
        end
        wr(1'h0, 8'h88);
        exec(rpd_pkg::OPC_STOP);
        check(8'(in_stop_q), 8'h01, "stop entered");
        check(8'(osc_run_q), 8'h00, "oscillator halted");
        filtered_external_irq = 2'h3;
        irq_enabled_any = 1'h1;
        repeat (20) step();
        check(8'(in_stop_q), 8'h01, "wake not refused");
        filtered_external_irq = 2'h0;
        irq_enabled_any = 1'h0;
        ext_clocked_irq = 1'h1;
        wait_for(1, STAB);
        ext_clocked_irq = 1'h0;
        check(8'(n >= STAB / 4 && n < STAB / 4 + 8), 8'h01, "settling length");
        check(8'(clk_seen), 8'h00, "cpu clock early");
        check(clock_divider_control_q, 8'h88, "divider changed");
        wr(1'h0, 8'h08);
        exec(rpd_pkg::OPC_IDLE);
        check(8'(in_idle_q), 8'h01, "idle entered");
        check(8'(osc_run_q), 8'h01, "oscillator kept");
        irq_enabled_any = 1'h1;
        wait_for(1, 4);
        irq_enabled_any = 1'h0;
        check(8'(in_idle_q), 8'h00, "idle left");
        check(clock_divider_control_q, 8'h08, "divider changed");
        wr(1'h1, 8'ha8);
        exec(rpd_pkg::OPC_STOP);
        filtered_external_irq = 2'h2;
        wait_for(1, STAB);
        filtered_external_irq = 2'h0;
        check(8'(n), 8'(3 + STAB / 16), "short settling");
        exec(rpd_pkg::OPC_IDLE);
        pin_req = 1'h1;
        step();
        pin_req = 1'h0;
        wait_for(4, 8);
        check(8'(n), 8'h03, "pin reset latency");
        step();
        check(8'(data_reset_q), 8'h00, "data not kept");
        check(clock_divider_control_q, 8'h00, "divider not slow");
        check(basic_timer_control_q, 8'h00, "timer control kept");
        check(8'(watchdog_en_q), 8'h01, "watchdog not armed");
        wait_for(0, STAB + 20);
        opt_internal_reset = 1'h1;
        supply_droop_reset = 1'h1;
        arst_n = 1'h0;
        step();
        arst_n = 1'h1;
        repeat (40) step();
        check(8'(ctrl_reset_q), 8'h01, "droop reset released");
        check(8'(reset_pin_is_port_q), 8'h01, "pin not a port");
        supply_droop_reset = 1'h0;
        wait_for(0, STAB + 8);
        pin_req = 1'h1;
        step();
        pin_req = 1'h0;
        repeat (12) step();
        check(8'(ctrl_reset_q), 8'h00, "pin reset in port mode");
        end_of_test();
    end
endmodule : rpd_top_bench
